// ==== design/smrc_pkg.sv ====
// package: register layout, field positions and timing constants of the run control block
package smrc_pkg;
   localparam int          CFG_W          = 24;
   localparam logic [23:0] CFG_RESET      = 24'h000000;
   localparam logic [23:0] CFG_WR_MASK    = 24'h01FFFF; // bits 23-17 reserved, read zero
   localparam int          BIT_SW_RESET   = 0;
   localparam int          POLL_PER_LSB   = 1;
   localparam int          ACT_TIME_LSB   = 5;
   localparam int          BIT_CRC_TRIG   = 9;
   localparam int          BIT_POLL_EN    = 10;
   localparam int          BIT_RUN        = 11;
   localparam int          CLK_MHZ        = 50;
   localparam int          ACT_STEP_US    = 64;
   localparam int          US_CYCLES      = CLK_MHZ;        // cycles per microsecond
   localparam int          MS_CYCLES      = CLK_MHZ * 1000; // cycles per millisecond
   localparam int          CRC_CYCLES     = 24;             // one cycle per config bit
   localparam logic [7:0]  CRC_INIT       = 8'hFF;
   localparam logic [7:0]  CRC_POLY       = 8'h1D;
   typedef enum logic [1:0] {SMRC_IDLE, SMRC_CONT, SMRC_ACTIVE, SMRC_WAIT} smrc_state_t;
endpackage : smrc_pkg

// ==== design/smrc_crc_if.sv ====
// interface: handshake between run control and the checksum engine
`timescale 1ns/1ns
`default_nettype none
interface smrc_crc_if;
   logic        start;
   logic [23:0] data;
   logic        done;
   logic [7:0]  result;
   modport ctrl (output start, output data, input done, input result);
   modport eng  (input start, input data, output done, output result);
endinterface : smrc_crc_if
`default_nettype wire

// ==== design/smrc_crc.sv ====
// checksum engine: serial crc over the configuration bits, one bit per clock
`timescale 1ns/1ns
`default_nettype none
module smrc_crc
   import smrc_pkg::*;
(
   input  wire logic   mclk,
   input  wire logic   rst,
   smrc_crc_if.eng     cif
);
   logic [23:0] shift_r;
   logic [7:0]  crc_r;
   logic [4:0]  cnt_r;
   logic        busy_r;
   logic        done_r;
   wire         fb_bit = crc_r[7] ^ shift_r[23];
   wire  [7:0]  crc_nxt = {crc_r[6:0], 1'b0} ^ (fb_bit ? CRC_POLY : 8'h00);

   // snapshot the config at start so later writes cannot change this run
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         shift_r <= 24'h000000;
         crc_r   <= CRC_INIT;
         cnt_r   <= 5'h00;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end
      else if (cif.start && !busy_r)
      begin
         shift_r <= cif.data;
         crc_r   <= CRC_INIT;
         cnt_r   <= 5'(CRC_CYCLES - 1);
         busy_r  <= 1'b1;
         done_r  <= 1'b0;
      end
      else if (busy_r)
      begin
         shift_r <= {shift_r[22:0], 1'b0};
         crc_r   <= crc_nxt;
         cnt_r   <= cnt_r - 5'h01;
         busy_r  <= (cnt_r != 5'h00);
         done_r  <= (cnt_r == 5'h00);
      end
      else
      begin
         done_r <= 1'b0;
      end
   end

   assign cif.done   = done_r;
   assign cif.result = crc_r;
endmodule : smrc_crc
`default_nettype wire

// ==== design/smrc_run_ctrl.sv ====
// run control for the switch monitor: config register, polling timer, checksum trigger
// Operation
// - writing run bit 11 to one starts wetting current and input sampling
// - clearing run bit stops operation; no current, no sampling
// - while running, run, checksum trigger, reset bit and comparator setup stay writable
// - bit 10 zero means continuous mode, one means polling mode
// - writing one to bit 9 starts checksum over all config bits
// - checksum done sets flag, drives interrupt low, loads result register
// - checksum trigger bit clears itself after the calculation
// - bits 8-5 pick active time, 64 us steps to 512, 128 us steps to 1024, then 2048, high codes 512
// - bits 4-1 pick period 2 ms to 4096 ms, high codes 8 ms
// - writing one to bit 0 triggers software reset; zero does nothing
// -----------------------------------------------------------------------------
// timing notes
// -----------------------------------------------------------------------------
// a config write is taken at the rising edge where cfg_wr is high
// readbacks and int_n lag their registers by one cycle, all from flops
// current and sampling follow a run write one edge later
// the sequencer leaves its phase within one cycle of a stop write
// checksum: snapshot of the old config, 24 busy cycles, done pulse, then flag
// the engine shifts the config msb first, one bit per clock
// the done flag is sticky; a set beats a clear in the same cycle
// a trigger while the engine is busy is refused and the trigger bit holds
// software reset: one-cycle strobe, then every register here returns to its reset value
// comparator setup has its own strobe and stays writable in every state
// writes to frozen bits while running are dropped without any error
// mode, active time and period are frozen while running, so a live change
// never corrupts the polling timer half way through a phase
// an active time at or above the period leaves a one-cycle off phase
// reserved bits and the reset bit always read back as zero
// the interrupt line idles high and goes low a cycle after the flag
// timing parameters give cycles per ms and per us; small values suit simulation
`timescale 1ns/1ns
`default_nettype none
module smrc_run_ctrl
   import smrc_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES, // cycles per ms, shorten in simulation
   parameter int US_CYC = US_CYCLES  // cycles per us, shorten in simulation
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        cfg_wr,
   input  wire logic [23:0] cfg_wdata,
   input  wire logic        comp_wr,
   input  wire logic [23:0] comp_wdata,
   input  wire logic        flag_clr,
   output logic      [23:0] cfg_rdata,
   output logic      [23:0] comp_rdata,
   output logic      [7:0]  crc_result,
   output logic             checksum_done_flag,
   output logic             int_n,
   output logic             wetting_on,
   output logic             sample_en,
   output logic             soft_reset
);
   // -------------------------------------------------------------------------
   // registers and decode
   // -------------------------------------------------------------------------
   // state, timer and output flops
   smrc_state_t  st_r, st_nxt;
   logic [23:0]  cfg_r;
   logic [23:0]  comp_r;
   logic [7:0]   crc_res_r;
   logic         flag_r;
   logic         srst_r;
   logic         crc_busy_r;
   logic [31:0]  tmr_r, tmr_nxt;
   logic         wet_r, smp_r;
   smrc_crc_if   cif ();

   // field decode of the stored config
   wire          running    = cfg_r[BIT_RUN];
   wire          poll_mode  = cfg_r[BIT_POLL_EN];
   wire  [3:0]   act_code   = cfg_r[ACT_TIME_LSB +: 4];
   wire  [3:0]   per_code   = cfg_r[POLL_PER_LSB +: 4];
   // strobes decoded straight from the bus word
   wire          sw_reset   = cfg_wr && cfg_wdata[BIT_SW_RESET];
   wire          crc_start  = cfg_wr && cfg_wdata[BIT_CRC_TRIG];
   // bits that may change while running; everything else is frozen then
   wire  [23:0]  live_mask  = (24'h1 << BIT_RUN) | (24'h1 << BIT_CRC_TRIG);
   // the trigger bit holds while a checksum runs and drops on its done pulse
   wire  [23:0]  trig_bit   = 24'h1 << BIT_CRC_TRIG;
   wire  [23:0]  trig_hold  = crc_busy_r ? trig_bit : 24'h000000;
   wire  [23:0]  trig_drop  = cif.done ? trig_bit : 24'h000000;
   wire  [23:0]  wr_mask    = (running ? live_mask : CFG_WR_MASK) & ~trig_hold;
   wire  [23:0]  cfg_wval   = (cfg_r & ~wr_mask) | (cfg_wdata & wr_mask);

   // -------------------------------------------------------------------------
   // timing decode
   // -------------------------------------------------------------------------
   // active time in microseconds
   function automatic int act_us(input logic [3:0] c);
      case (c)
         4'h8:    act_us = 640;
         4'h9:    act_us = 768;
         4'hA:    act_us = 896;
         4'hB:    act_us = 1024;
         4'hC:    act_us = 2048;
         4'hD, 4'hE, 4'hF: act_us = 512;
         default: act_us = (int'(c) + 1) * ACT_STEP_US;
      endcase
   endfunction : act_us

   // polling period in milliseconds
   function automatic int per_ms(input logic [3:0] c);
      case (c)
         4'h0:    per_ms = 2;
         4'h1:    per_ms = 4;
         4'h2:    per_ms = 8;
         4'h3:    per_ms = 16;
         4'h4:    per_ms = 32;
         4'h5:    per_ms = 48;
         4'h6:    per_ms = 64;
         4'h7:    per_ms = 128;
         4'h8:    per_ms = 256;
         4'h9:    per_ms = 512;
         4'hA:    per_ms = 1024;
         4'hB:    per_ms = 2048;
         4'hC:    per_ms = 4096;
         default: per_ms = 8;
      endcase
   endfunction : per_ms

   // phase lengths in clock cycles
   wire  [31:0]  act_cyc = 32'(act_us(act_code) * US_CYC);
   wire  [31:0]  per_cyc = 32'(per_ms(per_code) * MS_CYC);
   // an active time at or above the period would wrap the off count; clamp it
   wire  [31:0]  off_cyc = (per_cyc > act_cyc) ? per_cyc - act_cyc - 32'h1 : 32'h0;

   // -------------------------------------------------------------------------
   // config register
   // -------------------------------------------------------------------------
   // checksum trigger self-clears on done, even when a write lands in that cycle
   always_ff @(posedge mclk)
   begin
      if (rst || srst_r)
         cfg_r <= CFG_RESET;
      else if (cfg_wr)
         cfg_r <= cfg_wval & ~(24'h1 << BIT_SW_RESET) & ~trig_drop; // reset bit is a strobe
      else if (cif.done)
         cfg_r <= cfg_r & ~trig_bit;
   end

   // comparator setup stays writable even while running
   always_ff @(posedge mclk)
   begin
      if (rst || srst_r)
         comp_r <= 24'h000000;
      else if (comp_wr)
         comp_r <= comp_wdata;
   end

   // software reset strobe lasts one cycle, then clears all state
   always_ff @(posedge mclk)
   begin
      if (rst)
         srst_r <= 1'b0;
      else
         srst_r <= sw_reset;
   end

   // engine busy from an accepted start until its done pulse; triggers are refused then
   always_ff @(posedge mclk)
   begin
      if (rst || srst_r)
         crc_busy_r <= 1'b0;
      else if (cif.done)
         crc_busy_r <= 1'b0;
      else if (cif.start)
         crc_busy_r <= 1'b1;
   end

   // -------------------------------------------------------------------------
   // checksum result and done flag
   // -------------------------------------------------------------------------
   // set wins over clear so a completion is never lost
   always_ff @(posedge mclk)
   begin
      if (rst || srst_r)
      begin
         crc_res_r <= 8'h00;
         flag_r    <= 1'b0;
      end
      else
      begin
         if (cif.done)
            crc_res_r <= cif.result;
         flag_r <= cif.done | (flag_r & ~flag_clr);
      end
   end

   // start and snapshot handed to the engine
   assign cif.start = crc_start && !srst_r && !crc_busy_r;
   assign cif.data  = cfg_r;
   // the engine stops with a software reset too, so no stale result lands later
   wire          eng_rst    = rst || srst_r;

   smrc_crc u_crc
   (
      .mclk (mclk),
      .rst  (eng_rst),
      .cif  (cif)
   );

   // -------------------------------------------------------------------------
   // run sequencer
   // -------------------------------------------------------------------------
   // next state and timer; the timer counts down the current phase
   always_comb
   begin
      st_nxt  = st_r;
      tmr_nxt = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
      case (st_r)
         SMRC_IDLE:
         begin
            if (running && !poll_mode)
               st_nxt = SMRC_CONT;
            else if (running)
            begin
               st_nxt  = SMRC_ACTIVE;
               tmr_nxt = act_cyc - 32'h1;
            end
         end
         SMRC_CONT:
         begin
            if (!running)
               st_nxt = SMRC_IDLE;
         end
         SMRC_ACTIVE:
         begin
            if (!running)
               st_nxt = SMRC_IDLE;
            else if (tmr_r == 32'h0)
            begin
               st_nxt  = SMRC_WAIT;
               tmr_nxt = off_cyc;
            end
         end
         SMRC_WAIT:
         begin
            if (!running)
               st_nxt = SMRC_IDLE;
            else if (tmr_r == 32'h0)
            begin
               st_nxt  = SMRC_ACTIVE;
               tmr_nxt = act_cyc - 32'h1;
            end
         end
         default:
            st_nxt = SMRC_IDLE;
      endcase
   end

   // current and sampling decode the next state, so they switch with the state, from flops
   always_ff @(posedge mclk)
   begin
      if (rst || srst_r)
      begin
         st_r  <= SMRC_IDLE;
         tmr_r <= 32'h0;
         wet_r <= 1'b0;
         smp_r <= 1'b0;
      end
      else
      begin
         st_r  <= st_nxt;
         tmr_r <= tmr_nxt;
         wet_r <= (st_nxt == SMRC_CONT) || (st_nxt == SMRC_ACTIVE);
         smp_r <= (st_nxt == SMRC_CONT) || (st_nxt == SMRC_ACTIVE);
      end
   end

   // -------------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------------
   // read data registered so every output comes from a flop
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         cfg_rdata  <= 24'h000000;
         comp_rdata <= 24'h000000;
         int_n      <= 1'b1;
      end
      else
      begin
         cfg_rdata  <= cfg_r & CFG_WR_MASK;
         comp_rdata <= comp_r;
         int_n      <= ~flag_r;
      end
   end

   // remaining outputs are the flops themselves
   assign crc_result         = crc_res_r;
   assign checksum_done_flag = flag_r;
   assign wetting_on         = wet_r;
   assign sample_en          = smp_r;
   assign soft_reset         = srst_r;
endmodule : smrc_run_ctrl
`default_nettype wire

// ==== verif/smrc_run_ctrl_chk.sv ====
// checker: port-level assertions of the run control block
`timescale 1ns/1ns
`default_nettype none
module smrc_run_ctrl_chk #(
   parameter int MS_CYC = 50000,
   parameter int US_CYC = 50
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        cfg_wr,
   input  wire logic [23:0] cfg_wdata,
   input  wire logic        comp_wr,
   input  wire logic [23:0] comp_wdata,
   input  wire logic        flag_clr,
   input  wire logic [23:0] cfg_rdata,
   input  wire logic [23:0] comp_rdata,
   input  wire logic [7:0]  crc_result,
   input  wire logic        checksum_done_flag,
   input  wire logic        int_n,
   input  wire logic        wetting_on,
   input  wire logic        sample_en,
   input  wire logic        soft_reset
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // assertions: readback lags a cycle, so some skip the cycle after a write
   // ------------------------------------------------------------
   chk_run_start: assert property (
      cfg_wr && cfg_wdata[11:10] == 2'b10 && !cfg_wdata[0] && !cfg_rdata[11] && !$past(cfg_wr)
      |-> ##2 wetting_on) else $error("run write left current off");
   chk_stop_off: assert property (cfg_wr && !cfg_wdata[11] |-> ##2 !wetting_on)
      else $error("stop write left current on");
   chk_sample_pair: assert property (sample_en == wetting_on)
      else $error("sampling and current disagree");
   chk_comp_open: assert property (
      comp_wr && !soft_reset |-> ##2 comp_rdata == $past(comp_wdata, 2))
      else $error("comparator write lost");
   chk_crc_time: assert property (
      cfg_wr && cfg_wdata[9] && !cfg_wdata[0] && !cfg_rdata[9] && !checksum_done_flag
      && !$past(cfg_wr) |-> ##26 $rose(checksum_done_flag)) else $error("checksum late");
   chk_trig_clear: assert property ($rose(checksum_done_flag) |=> !cfg_rdata[9])
      else $error("trigger bit stuck");
   chk_int_follow: assert property (int_n == !$past(checksum_done_flag))
      else $error("interrupt line wrong");
   chk_soft_seq: assert property (cfg_wr && cfg_wdata[0] |=> soft_reset ##1 !soft_reset
      ##3 (!checksum_done_flag && !wetting_on && cfg_rdata == 24'h000000))
      else $error("soft reset incomplete");
   chk_no_reset: assert property (cfg_wr && !cfg_wdata[0] |=> !soft_reset)
      else $error("reset without request");
   chk_rsvd_zero: assert property (cfg_rdata[23:17] == 7'h00 && !cfg_rdata[0])
      else $error("reserved bits set");
   cover property (cfg_wr && cfg_wdata[9]);
   cover property ($rose(wetting_on) && cfg_rdata[10]);
   cover property (soft_reset);
endmodule : smrc_run_ctrl_chk
bind smrc_run_ctrl smrc_run_ctrl_chk #(.MS_CYC(MS_CYC), .US_CYC(US_CYC)) u_chk (
   .mclk(mclk), .rst(rst), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .comp_wr(comp_wr),
   .comp_wdata(comp_wdata), .flag_clr(flag_clr), .cfg_rdata(cfg_rdata),
   .comp_rdata(comp_rdata), .crc_result(crc_result), .int_n(int_n),
   .checksum_done_flag(checksum_done_flag), .wetting_on(wetting_on),
   .sample_en(sample_en), .soft_reset(soft_reset));
`default_nettype wire

// ==== verif/smrc_mcu_model.sv ====
// model of the controller that writes the run control registers
`timescale 1ns/1ns
`default_nettype none
module smrc_mcu_model (
   input  wire logic        mclk,
   input  wire logic        checksum_done_flag,
   output var  logic        cfg_wr,
   output var  logic [23:0] cfg_wdata,
   output var  logic        comp_wr,
   output var  logic [23:0] comp_wdata,
   output var  logic        flag_clr
);
   initial {cfg_wr, comp_wr, flag_clr, cfg_wdata, comp_wdata} = '0;
   // one-cycle writes; data toggles afterwards so a stale word never looks valid
   task wr(input logic [23:0] d);
      @(posedge mclk);
      {cfg_wr, cfg_wdata} <= {1'b1, d};
      @(posedge mclk);
      {cfg_wr, cfg_wdata} <= {1'b0, ~d};
   endtask : wr
   task wr_comp(input logic [23:0] d);
      @(posedge mclk);
      {comp_wr, comp_wdata} <= {1'b1, d};
      @(posedge mclk);
      {comp_wr, comp_wdata} <= {1'b0, ~d};
   endtask : wr_comp
   task clr();
      @(posedge mclk);
      flag_clr <= 1'b1;
      @(posedge mclk);
      flag_clr <= 1'b0;
   endtask : clr
   // settings change only while stopped, run is set again last
   task reconf(input logic [23:0] d);
      wr(24'h000000);
      wr(d);
      wr(d | 24'h000800);
   endtask : reconf
   // after a trigger nothing is written until the flag rises, bounded wait
   task crc(input logic [23:0] d);
      wr(d | 24'h000200);
      for (int n = 0; checksum_done_flag !== 1'b1 && n < 40; n++) @(negedge mclk);
   endtask : crc
endmodule : smrc_mcu_model
`default_nettype wire

// ==== verif/tb_top.sv ====
// testbench: random and corner scenarios for the run control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
$display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_top import smrc_pkg::*; ();
   localparam int P_MS = 100;
   localparam int P_US = 1;
   logic        mclk;
   logic        rst;
   logic        cfg_wr, comp_wr, flag_clr, done, int_n, wet, smp, srst;
   logic [23:0] cfg_wdata, comp_wdata, cfg_rdata, comp_rdata;
   logic [7:0]  crc_result;
   logic [31:0] seed = 32'hED97;
   int          num_errors = 0;
   int          comparisons = 0;
   int          pt [16] = '{2, 4, 8, 16, 32, 48, 64, 128, 256, 512, 1024, 2048, 4096, 8, 8, 8};
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   smrc_run_ctrl #(.MS_CYC(P_MS), .US_CYC(P_US)) dut (.mclk(mclk), .rst(rst),
      .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .comp_wr(comp_wr), .comp_wdata(comp_wdata),
      .flag_clr(flag_clr), .cfg_rdata(cfg_rdata), .comp_rdata(comp_rdata),
      .crc_result(crc_result), .checksum_done_flag(done), .int_n(int_n),
      .wetting_on(wet), .sample_en(smp), .soft_reset(srst));
   smrc_mcu_model mcu (.mclk(mclk), .checksum_done_flag(done), .cfg_wr(cfg_wr),
      .cfg_wdata(cfg_wdata), .comp_wr(comp_wr), .comp_wdata(comp_wdata), .flag_clr(flag_clr));
   // ------------------------------------------------------------
   // expectation helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic int act(input logic [3:0] a);
      return (a < 8 ? (a + 1) * 64 : a == 12 ? 2048 : a > 12 ? 512 : 640 + (a - 8) * 128) * P_US;
   endfunction : act
   // msb first over the snapshot taken before the trigger write
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'hFF;
      for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
      return c;
   endfunction : crc8
   task wt(input int n);
      repeat (n) @(negedge mclk);
   endtask : wt
   // one period measured at the enable; the first rise follows the run write
   task poll(input logic [3:0] a, input logic [3:0] p);
      int h, l;
      mcu.reconf({15'h0000, a, p, 1'b0} | 24'h000400);
      for (l = 0; wet !== 1'b1 && l < 20; l++) @(negedge mclk);
      `CHK("sample", 1'b1, smp)
      for (h = 0; wet === 1'b1 && h < 5000; h++) @(negedge mclk);
      for (l = 0; wet !== 1'b1 && l < 9000; l++) @(negedge mclk);
      `CHK("active", act(a), h)
      `CHK("period", pt[p] * P_MS, h + l)
   endtask : poll
   task test_done();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : test_done
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      logic [23:0] d;
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      wt(1);
      `CHK("int_n", 1'b1, int_n)
      for (int i = 0; i < 8; i++)
      begin
         d = 24'(xs()) & 24'hFFF5FE;
         mcu.wr(d);
         wt(2);
         `CHK("cfg", d & CFG_WR_MASK, cfg_rdata)
      end
      d = 24'(xs());
      mcu.reconf(24'h000000);
      wt(100);
      `CHK("cont", 1'b1, wet)
      mcu.wr_comp(d);
      mcu.wr(24'h00081E);
      wt(2);
      `CHK("cfg", 24'h000800, cfg_rdata)
      `CHK("comp", d, comp_rdata)
      mcu.wr(24'h000000);
      wt(50);
      `CHK("stop", 1'b0, wet | smp)
      // checksum once stopped and once running
      for (int r = 0; r < 2; r++)
      begin
         d = 24'(xs()) & 24'h01F5FE;
         mcu.wr(d);
         d = d | (r ? 24'h000800 : 24'h000000);
         mcu.wr(d);
         mcu.crc(d);
         wt(1);
         `CHK("crc", crc8(d), crc_result)
         `CHK("int_n", 1'b0, int_n)
         `CHK("trig", 1'b0, cfg_rdata[9])
         mcu.clr();
         mcu.wr(24'h000000);
         wt(30);
         `CHK("flag", 1'b0, done)
      end
      mcu.wr(24'h000800);
      mcu.wr(24'h000801);
      wt(1);
      `CHK("srst", 1'b1, srst)
      wt(3);
      `CHK("soft", 1'b0, |{cfg_rdata, comp_rdata, wet})
      for (int a = 0; a < 16; a++) poll(4'(a), a == 12 ? 4'h4 : 4'h3);
      for (int p = 0; p < 16; p++) if (p < 7 || p > 12) poll(4'h0, 4'(p));
      test_done();
   end
   initial
   begin
      repeat (100000) @(posedge mclk);
      num_errors++;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
